// File: jts_tap.v
// Purpose: boundary-scan test access port of a memory device
// Assumes: clk far faster than tck; tck, tms, tdi, trst-free
// Notes:   tck edges found by sampling; tap resets via tms high
`timescale 1ns/10ps
`default_nettype none
`include "jts_map.vh"
module jts_tap #(
   parameter [2:0]  ID_VERSION = 3'h5,     // arbitrary value
   parameter [16:0] ID_PART    = 17'h00001, // arbitrary value
   parameter [10:0] ID_MFR     = 11'h001   // arbitrary value
) (
   input  wire           clk,
   input  wire           rst,
   input  wire           tck,
   input  wire           tms,
   input  wire           tdi,
   output reg            tdo,
   output reg            tdo_oe,
   input  wire [107:0]   pin_in,
   output reg  [107:0]   pin_out,
   output reg            pin_test_mode,
   output reg            q_bus_oe_n_force
);
   wire [2:0]   s;
   reg          tck_d;
   reg  [3:0]   st;
   reg  [3:0]   next_st;
   reg  [2:0]   ir_sh;
   reg  [2:0]   ir;
   reg          byp;
   reg  [31:0]  id_sh;
   reg  [108:0] bsr_sh;
   reg  [108:0] bsr_upd;
   reg          tdo_next;
   wire         rise;
   wire         fall;
   wire [31:0]  id_value;
   wire [107:0] pin_s;

   // ------------------------------------------------------------
   // tap state codes
   // ------------------------------------------------------------
   // binary codes; an unknown code falls back to test-logic-reset
   localparam [3:0] ST_RESET  = `JTS_ST_RESET;
   localparam [3:0] ST_IDLE   = `JTS_ST_IDLE;
   localparam [3:0] ST_SEL_DR = `JTS_ST_SEL_DR;
   localparam [3:0] ST_CAP_DR = `JTS_ST_CAP_DR;
   localparam [3:0] ST_SH_DR  = `JTS_ST_SH_DR;
   localparam [3:0] ST_EX1_DR = `JTS_ST_EX1_DR;
   localparam [3:0] ST_PAU_DR = `JTS_ST_PAU_DR;
   localparam [3:0] ST_EX2_DR = `JTS_ST_EX2_DR;
   localparam [3:0] ST_UPD_DR = `JTS_ST_UPD_DR;
   localparam [3:0] ST_SEL_IR = `JTS_ST_SEL_IR;
   localparam [3:0] ST_CAP_IR = `JTS_ST_CAP_IR;
   localparam [3:0] ST_SH_IR  = `JTS_ST_SH_IR;
   localparam [3:0] ST_EX1_IR = `JTS_ST_EX1_IR;
   localparam [3:0] ST_PAU_IR = `JTS_ST_PAU_IR;
   localparam [3:0] ST_EX2_IR = `JTS_ST_EX2_IR;
   localparam [3:0] ST_UPD_IR = `JTS_ST_UPD_IR;

   // ------------------------------------------------------------
   // pin sampling and edge detection
   // ------------------------------------------------------------
   // tms and tdi share the tck flops so they line up with its edges
   jts_sync #(.W(3)) u_sync (
      .clk  (clk),
      .rst  (rst),
      .din  ({tck, tms, tdi}),
      .dout (s)
   );
   // captured levels come from the memory clock domain
   jts_sync #(.W(`JTS_EXT_LEN)) u_pin_sync (
      .clk  (clk),
      .rst  (rst),
      .din  (pin_in),
      .dout (pin_s)
   );
   assign rise = s[2] & ~tck_d;
   assign fall = ~s[2] & tck_d;

   assign id_value = {ID_VERSION, ID_PART, ID_MFR,
                      `JTS_ID_PRESENT};

   // scan instructions share the boundary chain
   function is_bsr;
      input [2:0] code;
      begin
         is_bsr = (code == `JTS_IR_EXTEST) ||
                  (code == `JTS_IR_SAMPLE_Z) ||
                  (code == `JTS_IR_SAMPLE);
      end
   endfunction

   // ------------------------------------------------------------
   // tap state machine
   // ------------------------------------------------------------
   always @* begin
      // tms passed the same two flops as tck, so it is settled at a rise
      case (st)
         ST_RESET:  next_st = s[1] ? ST_RESET : ST_IDLE;
         ST_IDLE:   next_st = s[1] ? ST_SEL_DR : ST_IDLE;
         ST_SEL_DR: next_st = s[1] ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: next_st = s[1] ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR:  next_st = s[1] ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: next_st = s[1] ? ST_UPD_DR : ST_PAU_DR;
         ST_PAU_DR: next_st = s[1] ? ST_EX2_DR : ST_PAU_DR;
         ST_EX2_DR: next_st = s[1] ? ST_UPD_DR : ST_SH_DR;
         ST_UPD_DR: next_st = s[1] ? ST_SEL_DR : ST_IDLE;
         ST_SEL_IR: next_st = s[1] ? ST_RESET : ST_CAP_IR;
         ST_CAP_IR: next_st = s[1] ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR:  next_st = s[1] ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: next_st = s[1] ? ST_UPD_IR : ST_PAU_IR;
         ST_PAU_IR: next_st = s[1] ? ST_EX2_IR : ST_PAU_IR;
         ST_EX2_IR: next_st = s[1] ? ST_UPD_IR : ST_SH_IR;
         ST_UPD_IR: next_st = s[1] ? ST_SEL_DR : ST_IDLE;
         default:   next_st = ST_RESET;
      endcase
   end

   // ------------------------------------------------------------
   // instruction and data registers, stepped on rising tck
   // ------------------------------------------------------------
   always @(posedge clk) begin
      if (rst) begin
         tck_d   <= 1'b0;
         st      <= ST_RESET;
         ir_sh   <= `JTS_IR_IDCODE;
         ir      <= `JTS_IR_IDCODE;
         byp     <= 1'b0;
         id_sh   <= 32'h0000_0000;
         bsr_sh  <= {`JTS_BSR_LEN{1'b0}};
         bsr_upd <= {`JTS_BSR_LEN{1'b0}};
      end else begin
         tck_d <= s[2];
         if (rise) begin
            st <= next_st;
            case (st)
               ST_RESET: begin
                  ir <= `JTS_IR_IDCODE;
                  // output-enable cell cleared in test-logic-reset
                  bsr_upd[`JTS_BSR_OE_CELL] <= 1'b0;
               end
               ST_CAP_IR: ir_sh <= `JTS_IR_CAPTURE;
               ST_SH_IR:  ir_sh <= {s[0], ir_sh[2:1]};
               // reserved codes are not screened here
               ST_UPD_IR: ir <= ir_sh;
               ST_CAP_DR: begin
                  byp <= 1'b0;
                  if (ir == `JTS_IR_IDCODE)
                     id_sh <= id_value;
                  // internal cell keeps its shift content
                  if (is_bsr(ir))
                     bsr_sh[107:0] <= pin_s;
               end
               ST_SH_DR: begin
                  if (ir == `JTS_IR_IDCODE)
                     id_sh <= {s[0], id_sh[31:1]};
                  else if (is_bsr(ir))
                     bsr_sh <= {s[0], bsr_sh[108:1]};
                  else
                     byp <= s[0];
               end
               ST_UPD_DR:
                  if (is_bsr(ir))
                     bsr_upd <= bsr_sh;
               default: ;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // tdo source, launched on falling tck
   // ------------------------------------------------------------
   always @* begin
      if (st == ST_SH_IR)
         tdo_next = ir_sh[0];
      else if (ir == `JTS_IR_IDCODE)
         tdo_next = id_sh[0];
      else if (is_bsr(ir))
         tdo_next = bsr_sh[0];
      else
         tdo_next = byp;
   end

   always @(posedge clk) begin
      if (rst) begin
         tdo              <= 1'b0;
         tdo_oe           <= 1'b0;
         pin_out          <= {`JTS_EXT_LEN{1'b0}};
         pin_test_mode    <= 1'b0;
         q_bus_oe_n_force <= 1'b0;
      end else begin
         // launched at the fall so the controller samples a settled bit
         if (fall) begin
            tdo    <= tdo_next;
            // driven only while shifting, so a shared chain sees one driver
            tdo_oe <= (st == ST_SH_IR) || (st == ST_SH_DR);
         end
         pin_out       <= bsr_upd[107:0];
         pin_test_mode <= (ir == `JTS_IR_EXTEST);
         // sample-z floats always; extest floats on low cell 108
         q_bus_oe_n_force <= (ir == `JTS_IR_SAMPLE_Z) ||
            ((ir == `JTS_IR_EXTEST) && !bsr_upd[`JTS_BSR_OE_CELL]);
      end
   end
endmodule
`default_nettype wire

// File: jts_map.vh
// Purpose: constants of the test access port logic
// Assumes: included by its bare name
// Notes:   instruction codes, register lengths, id layout
`ifndef JTS_MAP_VH
`define JTS_MAP_VH
`define JTS_IR_LEN        3
`define JTS_BSR_LEN       109
`define JTS_ID_LEN        32
`define JTS_BSR_OE_CELL   108
`define JTS_EXT_LEN       108
`define JTS_IR_EXTEST     3'h0
`define JTS_IR_IDCODE     3'h1
`define JTS_IR_SAMPLE_Z   3'h2
`define JTS_IR_SAMPLE     3'h4
`define JTS_IR_BYPASS     3'h7
`define JTS_IR_CAPTURE    3'h1
`define JTS_ID_VER_MSB    31
`define JTS_ID_VER_LSB    29
`define JTS_ID_PART_MSB   28
`define JTS_ID_PART_LSB   12
`define JTS_ID_MFR_MSB    11
`define JTS_ID_MFR_LSB    1
`define JTS_ID_PRESENT    1'h1
`define JTS_ST_RESET      4'h0
`define JTS_ST_IDLE       4'h1
`define JTS_ST_SEL_DR     4'h2
`define JTS_ST_CAP_DR     4'h3
`define JTS_ST_SH_DR      4'h4
`define JTS_ST_EX1_DR     4'h5
`define JTS_ST_PAU_DR     4'h6
`define JTS_ST_EX2_DR     4'h7
`define JTS_ST_UPD_DR     4'h8
`define JTS_ST_SEL_IR     4'h9
`define JTS_ST_CAP_IR     4'hA
`define JTS_ST_SH_IR      4'hB
`define JTS_ST_EX1_IR     4'hC
`define JTS_ST_PAU_IR     4'hD
`define JTS_ST_EX2_IR     4'hE
`define JTS_ST_UPD_IR     4'hF
`endif

// File: jts_sync.v
// Purpose: two-flop synchroniser for a group of pin inputs
// Assumes: inputs asynchronous to clk
// Notes:   first stage read only by the second stage
`timescale 1ns/10ps
`default_nettype none
module jts_sync #(
   parameter W = 4
) (
   input  wire         clk,
   input  wire         rst,
   input  wire [W-1:0] din,
   output reg  [W-1:0] dout
);
   reg [W-1:0] meta;
   always @(posedge clk) begin
      if (rst) begin
         meta <= {W{1'b0}};
         dout <= {W{1'b0}};
      end else begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule
`default_nettype wire

// File: jts_tap_monitor.sv
// Purpose: port checker for the test access port
// Assumes: tck moves just after clk edges, four clk per phase
// Notes:   bound to jts_tap below
`timescale 1ns/10ps
`default_nettype none
module jts_mon (
   input wire logic         clk,
   input wire logic         rst,
   input wire logic         tck,
   input wire logic         tms,
   input wire logic         tdi,
   input wire logic         tdo,
   input wire logic         tdo_oe,
   input wire logic [107:0] pin_in,
   input wire logic [107:0] pin_out,
   input wire logic         pin_test_mode,
   input wire logic         q_bus_oe_n_force
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // ----------------------------------------------
   // reset clears outputs; tdo moves only after a falling tck, pin outputs only after a rising one
   // ----------------------------------------------
   rst_clears_a:
      assert property ($fell(rst) |-> !tdo && !tdo_oe && !pin_out
         && !pin_test_mode && !q_bus_oe_n_force) else $error("no reset");
   tdo_fall_a:
      assert property ($changed(tdo) |-> !$past(tck, 2))
         else $error("tdo moved with tck high");
   tdo_slot_a:
      assert property ($changed(tdo) |-> $past(tck, 4) && !$past(tck, 3))
         else $error("tdo moved off its launch slot");
   oe_slot_a:
      assert property ($changed(tdo_oe) |-> $past(tck, 4) && !$past(tck, 3))
         else $error("tdo_oe moved off its launch slot");
   pout_rise_a:
      assert property ($changed(pin_out) |-> $past(tck) || $past(tck, 2))
         else $error("pin_out moved off update");
   pout_slot_a:
      assert property ($changed(pin_out) |-> $past(tck, 4) && !$past(tck, 5))
         else $error("pin_out moved off its update slot");
   mode_rise_a:
      assert property ($changed(pin_test_mode) |-> $past(tck) || $past(tck, 2))
         else $error("test mode moved off update");
   force_rise_a:
      assert property ($changed(q_bus_oe_n_force) |-> $past(tck)
         || $past(tck, 2)) else $error("force moved off update");
   force_slot_a:
      assert property ($changed(q_bus_oe_n_force) |-> $past(tck, 4)
         && !$past(tck, 5)) else $error("force moved off its update slot");
   cover property (pin_test_mode && q_bus_oe_n_force);
   cover property ($rose(tdo_oe));
   cover property ($rose(q_bus_oe_n_force) && !pin_test_mode);
endmodule
bind jts_tap jts_mon jts_mon_i (.clk(clk), .rst(rst), .tck(tck), .tms(tms),
   .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .pin_in(pin_in), .pin_out(pin_out),
   .pin_test_mode(pin_test_mode), .q_bus_oe_n_force(q_bus_oe_n_force));
`default_nettype wire

// File: jts_ctl.sv
// Purpose: boundary-scan controller model
// Assumes: 8 clk per tck period, tck low when idle
// Notes:   tdo taken just before each rise
`timescale 1ns/10ps
`default_nettype none
module jts_ctl (
   input  wire logic clk,
   input  wire logic tdo,
   output var  logic tck,
   output var  logic tms,
   output var  logic tdi
);
   initial begin
      tck = 1'h0;
      tms = 1'h1;
      tdi = 1'h0;
   end
   // ----------------------------------------------
   // one tck period; tms and tdi move at the fall
   // ----------------------------------------------
   task step(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      repeat (4) @(posedge clk);
      #1 q = tdo;
      tck = 1'h1;
      repeat (4) @(posedge clk);
      #1 tck = 1'h0;
   endtask
   task tlr;
      logic q;
      repeat (5) step(1'h1, 1'h0, q);
      step(1'h0, 1'h0, q);
   endtask
   // ir or dr scan from idle back to idle, lsb first
   task shift(input logic ir, input int n, input logic [108:0] din,
              output logic [108:0] dout);
      logic q;
      dout = '0;
      step(1'h1, 1'h0, q);
      if (ir) step(1'h1, 1'h0, q);
      step(1'h0, 1'h0, q);
      step(1'h0, 1'h0, q);
      for (int k = 0; k < n; k++) begin
         step(k == n - 1, din[k], q);
         dout[k] = q;
      end
      step(1'h1, 1'h0, q);
      step(1'h0, 1'h0, q);
   endtask
endmodule
`default_nettype wire

// File: jts_tap_tb.sv
// Purpose: self-checking bench of jts_tap
// Assumes: default id parameters
// Notes:   only defined codes are loaded
`timescale 1ns/10ps
`default_nettype none
`include "jts_map.vh"
module jts_tap_tb;
   localparam logic [31:0] ID = {3'h5, 17'h00001, 11'h001, `JTS_ID_PRESENT};
   logic         clk, rst, tck, tms, tdi, tdo, tdo_oe, mode, frc;
   logic [107:0] pin_in, pin_out;
   logic [108:0] v, r;
   logic         q;
   int           bad_count, n_tests;
   initial begin
      clk = 1'h0;
      forever #20 clk = ~clk;
   end
   jts_tap jts_tap_i (.clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
      .tdo(tdo), .tdo_oe(tdo_oe), .pin_in(pin_in), .pin_out(pin_out),
      .pin_test_mode(mode), .q_bus_oe_n_force(frc));
   jts_ctl jts_ctl_i (.clk(clk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));
   // ----------------------------------------------
   // checks and scenarios
   // ----------------------------------------------
   task chk(input logic [109:0] got, input logic [109:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task t_id;
      chk({mode, frc, pin_out}, '0);
      jts_ctl_i.tlr();
      jts_ctl_i.shift(0, 32, '0, r);
      chk(r[31:0], ID);
      jts_ctl_i.shift(1, 3, `JTS_IR_IDCODE, r);
      chk(r[2:0], `JTS_IR_CAPTURE);
      jts_ctl_i.shift(0, 33, '0, r);
      chk(r[32:0], {1'h0, ID});
      chk(tdo_oe, 1'h0);
   endtask
   task t_bypass;
      jts_ctl_i.shift(1, 3, `JTS_IR_BYPASS, r);
      jts_ctl_i.shift(0, 3, 109'h5, r);
      chk(r[2:0], 3'h2);
      jts_ctl_i.step(1'h1, 1'h0, q);
      jts_ctl_i.step(1'h0, 1'h0, q);
      jts_ctl_i.step(1'h0, 1'h0, q);
      jts_ctl_i.step(1'h0, 1'h1, q);
      chk({tdo_oe, q}, 2'h2);
      jts_ctl_i.step(1'h1, 1'h0, q);
      chk(q, 1'h1);
      jts_ctl_i.step(1'h1, 1'h0, q);
      jts_ctl_i.step(1'h0, 1'h0, q);
      chk(tdo_oe, 1'h0);
   endtask
   task t_sample;
      pin_in = {27{4'hA}};
      v = {1'h1, {27{4'h5}}};
      jts_ctl_i.shift(1, 3, `JTS_IR_SAMPLE, r);
      jts_ctl_i.shift(0, 109, v, r);
      chk(r[107:0], pin_in);
      chk({mode, frc, pin_out}, {2'h0, v[107:0]});
      pin_in = ~pin_in;
      jts_ctl_i.shift(0, 109, v, r);
      chk(r, {v[108], pin_in});
   endtask
   task t_extest;
      jts_ctl_i.shift(1, 3, `JTS_IR_EXTEST, r);
      chk({mode, frc}, 2'h2);
      v[108] = 1'h0;
      jts_ctl_i.shift(0, 109, v, r);
      chk(r[107:0], pin_in);
      chk({mode, frc}, 2'h3);
   endtask
   task t_samplez;
      jts_ctl_i.shift(1, 3, `JTS_IR_SAMPLE_Z, r);
      chk({mode, frc}, 2'h1);
      jts_ctl_i.shift(0, 109, v, r);
      chk(r[107:0], pin_in);
      jts_ctl_i.tlr();
      jts_ctl_i.shift(0, 32, '0, r);
      chk({mode, frc, r[31:0]}, {2'h0, ID});
      jts_ctl_i.shift(1, 3, `JTS_IR_EXTEST, r);
      chk({mode, frc}, 2'h3);
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      rst = 1'h1;
      pin_in = '0;
      bad_count = 0;
      n_tests = 0;
      repeat (5) @(posedge clk);
      #1 rst = 1'h0;
      t_id();
      t_bypass();
      t_sample();
      t_extest();
      t_samplez();
      wrap_up();
   end
   initial begin
      #2000000 bad_count++;
      wrap_up();
   end
endmodule
`default_nettype wire
